// *** shared/ppc_pkg.sv ***
// Constants and types shared by the parallel port controller.
package ppc_pkg;
  // Register offsets on the host register port.
  localparam logic [10:0] OFS_CTRL = 11'h002;
  localparam logic [10:0] OFS_EADDR = 11'h003;
  localparam logic [10:0] OFS_EDATA_LO = 11'h004;
  localparam logic [10:0] OFS_EDATA_HI = 11'h007;
  localparam logic [10:0] OFS_FIFO = 11'h400;
  localparam logic [10:0] OFS_EXT_CTRL = 11'h402;
  localparam logic [10:0] OFS_IRQ_STAT = 11'h404;
  localparam logic [10:0] OFS_IRQ_MASK = 11'h405;
  localparam logic [10:0] OFS_ENG_STAT = 11'h406;
  // Field positions of the line control register.
  localparam int CTRL_DIR = 5;
  localparam int CTRL_ACKIRQ = 4;
  localparam int CTRL_SELIN = 3;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_AFD = 1;
  localparam int CTRL_STB = 0;
  localparam logic [1:0] CTRL_RSVD = 2'h3;
  // Interrupt status bit positions.
  localparam int IRQ_ACK = 0;
  localparam int IRQ_TMO = 1;
  // Configuration A content: level interrupt, 8-bit, full excludes byte.
  localparam logic CFGA_IRQ_LEVEL = 1'h1;
  localparam logic [2:0] CFGA_WIDTH_ID = 3'h1;
  localparam logic CFGA_FULL_SEM = 1'h0;
  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // Timing in nanoseconds and derived cycle counts at 200 MHz.
  localparam int CLK_NS = 5;
  localparam int TMO_NS = 10000;
  localparam int CMP_STB_NS = 500;
  localparam logic [11:0] TMO_CYC = 12'(TMO_NS / CLK_NS);
  localparam logic [11:0] CMP_STB_CYC =
    12'((CMP_STB_NS + CLK_NS - 1) / CLK_NS);
  // Queue geometry.
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL_CNT = 5'h10;
  // Operating mode codes.
  typedef enum logic [2:0] {
    MODE_COMPAT = 3'h0, MODE_BIDIR = 3'h1, MODE_DFIFO = 3'h2,
    MODE_EXTCAP = 3'h3, MODE_ENH = 3'h4, MODE_RSVD = 3'h5,
    MODE_TEST = 3'h6, MODE_CONFIG = 3'h7
  } port_operating_mode_t;
  // Handshake engine states, one-hot.
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001, ST_EPP_STB = 10'h002, ST_EPP_REL = 10'h004,
    ST_CMP_SETUP = 10'h008, ST_CMP_STB = 10'h010, ST_CMP_WAIT = 10'h020,
    ST_XF_CLK = 10'h040, ST_XF_REL = 10'h080, ST_XR_WAIT = 10'h100,
    ST_XR_REL = 10'h200
  } eng_state_t;
endpackage

// *** verilog/parallel_port_ctrl_fifo_regs.sv ***
// Host parallel port: line control, enhanced cycles and the mode window.
`timescale 1ns/1ps
module parallel_port_ctrl_fifo_regs (
  // Clock and synchronous reset.
  input wire logic clk_i,
  input wire logic rstn_i,
  // Host register port.
  input wire logic [10:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Interrupt.
  output logic irq_o,
  // Cable data lines, two-way.
  input wire logic [7:0] pd_i,
  output logic [7:0] pd_o,
  output logic pd_oe_o,
  // Cable control outputs, active low.
  output logic strobe_n_o,
  output logic auto_feed_n_o,
  output logic init_n_o,
  output logic select_in_n_o,
  // Cable status inputs.
  input wire logic ack_n_i,
  input wire logic busy_i
);
  // Stored control bits.
  logic ctrl_dir, ctrl_ackirq, ctrl_selin, ctrl_init, ctrl_afd, ctrl_stb;
  // Current operating mode.
  ppc_pkg::port_operating_mode_t mode;
  // Interrupt status and mask.
  logic [1:0] irq_stat, irq_mask;
  // Engine state, cycle counter and latched cycle attributes.
  ppc_pkg::eng_state_t state, next_state;
  logic [11:0] cnt;
  logic eng_addr, eng_wr;
  logic [7:0] eng_byte, epp_rx;
  // Input synchronisers; ack_d follows ack_s2 for edge detection.
  logic ack_s1, ack_s2, ack_d, busy_s1, busy_s2;
  logic [7:0] pd_s1, pd_s2;
  // Queue storage and pointers.
  logic [7:0] fifo_mem [ppc_pkg::FIFO_DEPTH];
  logic [4:0] wr_ptr, rd_ptr;

  // Address decode.
  wire hit_ctrl = addr_i == ppc_pkg::OFS_CTRL;
  wire hit_eaddr = addr_i == ppc_pkg::OFS_EADDR;
  wire hit_edata = (addr_i >= ppc_pkg::OFS_EDATA_LO) &&
                   (addr_i <= ppc_pkg::OFS_EDATA_HI);
  wire hit_fifo = addr_i == ppc_pkg::OFS_FIFO;
  wire hit_ext = addr_i == ppc_pkg::OFS_EXT_CTRL;
  wire hit_istat = addr_i == ppc_pkg::OFS_IRQ_STAT;
  wire hit_imask = addr_i == ppc_pkg::OFS_IRQ_MASK;
  wire hit_estat = addr_i == ppc_pkg::OFS_ENG_STAT;
  // Mode conditions.
  wire m_compat = mode == ppc_pkg::MODE_COMPAT;
  wire m_dfifo = mode == ppc_pkg::MODE_DFIFO;
  wire m_xc = mode == ppc_pkg::MODE_EXTCAP;
  wire m_enh = mode == ppc_pkg::MODE_ENH;
  wire m_test = mode == ppc_pkg::MODE_TEST;
  wire m_cfg = mode == ppc_pkg::MODE_CONFIG;
  wire idle = state == ppc_pkg::ST_IDLE;
  // Queue levels; full excludes the byte held by the engine.
  wire [4:0] fifo_cnt = wr_ptr - rd_ptr;
  wire fifo_full = fifo_cnt == ppc_pkg::FIFO_FULL_CNT;
  wire fifo_empty = fifo_cnt == 5'h00;
  wire [7:0] fifo_head = fifo_mem[rd_ptr[3:0]];
  // Synchronised cable events.
  wire ack_rise = ack_s2 && !ack_d;
  wire tmo_hit = cnt == (ppc_pkg::TMO_CYC - 12'h001);

  // Enhanced cycles start from a host access in enhanced mode when idle.
  wire epp_acc = (wr_i || rd_i) && (hit_eaddr || hit_edata);
  wire epp_go = epp_acc && m_enh && idle;
  // Queue drains or fills only in the matching mode.
  wire cmp_go = m_dfifo && !fifo_empty;
  wire xf_go = m_xc && !ctrl_dir && !fifo_empty;
  wire xr_go = m_xc && ctrl_dir && !fifo_full;
  // Host queue accesses per mode at the 400h window.
  wire host_push = wr_i && hit_fifo && !fifo_full &&
                   (m_dfifo || (m_xc && !ctrl_dir) || m_test);
  wire host_pop = rd_i && hit_fifo && !fifo_empty &&
                  ((m_xc && ctrl_dir) || m_test);
  // Engine queue accesses happen at a launch or a reverse capture.
  wire eng_pop = idle && !epp_go && (cmp_go || (!m_dfifo && xf_go));
  wire eng_push = (state == ppc_pkg::ST_XR_WAIT) && !ack_s2 && xr_go;
  wire push = host_push || eng_push;
  wire pop = host_pop || eng_pop;

  // Read-back values.
  wire [7:0] ctrl_rd = {ppc_pkg::CTRL_RSVD, ctrl_dir, ctrl_ackirq,
                        !select_in_n_o, init_n_o, !auto_feed_n_o,
                        !strobe_n_o};
  wire [7:0] cfga_rd = {ppc_pkg::CFGA_IRQ_LEVEL, ppc_pkg::CFGA_WIDTH_ID,
                        1'h0, ppc_pkg::CFGA_FULL_SEM,
                        2'h0};
  wire [7:0] win_rd = m_cfg ? cfga_rd : (host_pop ? fifo_head : 8'h00);
  wire [7:0] ext_rd = {mode, 3'h0, fifo_full, fifo_empty};
  wire [7:0] next_rdata = !rd_i ? 8'h00 :
                          hit_ctrl ? ctrl_rd :
                          (hit_eaddr || hit_edata) ? epp_rx :
                          hit_fifo ? win_rd :
                          hit_ext ? ext_rd :
                          hit_istat ? {6'h00, irq_stat} :
                          hit_imask ? {6'h00, irq_mask} :
                          hit_estat ? {7'h00, !idle} : 8'h00;

  // Direction is held at output whenever compatibility mode is set.
  wire next_dir = m_compat ? 1'h0 :
                  (wr_i && hit_ctrl) ? wdata_i[ppc_pkg::CTRL_DIR] :
                  ctrl_dir;
  // Sticky events: a set in the same cycle wins over a write-one clear.
  wire [1:0] irq_set = {(state == ppc_pkg::ST_EPP_STB ||
                         state == ppc_pkg::ST_EPP_REL) && tmo_hit,
                        ack_rise && ctrl_ackirq};
  wire [1:0] irq_clr = (wr_i && hit_istat) ? wdata_i[1:0] : 2'h0;
  wire [1:0] next_irq = (irq_stat & ~irq_clr) | irq_set;

  // Two flip-flop synchronisers for cable inputs plus an edge stage.
  always_ff @(posedge clk_i) begin
    ack_s1 <= ack_n_i;
    ack_s2 <= ack_s1;
    ack_d <= ack_s2;
    busy_s1 <= busy_i;
    busy_s2 <= busy_s1;
    pd_s1 <= pd_i;
    pd_s2 <= pd_s1;
  end

  // Control register and mode register.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      {ctrl_ackirq, ctrl_selin, ctrl_init, ctrl_afd, ctrl_stb} <=
        ppc_pkg::CTRL_RST[4:0];
      ctrl_dir <= ppc_pkg::CTRL_RST[ppc_pkg::CTRL_DIR];
      mode <= ppc_pkg::MODE_COMPAT;
    end else begin
      ctrl_dir <= next_dir;
      if (wr_i && hit_ctrl) begin
        {ctrl_ackirq, ctrl_selin, ctrl_init, ctrl_afd, ctrl_stb} <=
          wdata_i[4:0];
      end
      if (wr_i && hit_ext) begin
        mode <= ppc_pkg::port_operating_mode_t'(wdata_i[7:5]);
      end
    end
  end

  // Interrupt status, mask and the level output.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      irq_stat <= ppc_pkg::IRQ_RST;
      irq_mask <= ppc_pkg::IRQ_RST;
      irq_o <= 1'h0;
    end else begin
      irq_stat <= next_irq;
      if (wr_i && hit_imask) begin
        irq_mask <= wdata_i[1:0];
      end
      irq_o <= |(next_irq & irq_mask);
    end
  end

  // Read data appear in the cycle after the read strobe only.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // Queue storage; the array itself needs no reset.
  always_ff @(posedge clk_i) begin
    if (push) begin
      fifo_mem[wr_ptr[3:0]] <= eng_push ? pd_s2 : wdata_i;
    end
  end

  // Queue pointers.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_ptr <= 5'h00;
      rd_ptr <= 5'h00;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 5'h01;
      end
    end
  end

  // Engine next state; waits end on the cable's answer, the enhanced timeout or a stop of reverse capture.
  always_comb begin
    next_state = state;
    case (state)
      ppc_pkg::ST_IDLE: begin
        if (epp_go) begin
          next_state = ppc_pkg::ST_EPP_STB;
        end else if (cmp_go) begin
          next_state = ppc_pkg::ST_CMP_SETUP;
        end else if (xf_go) begin
          next_state = ppc_pkg::ST_XF_CLK;
        end else if (xr_go) begin
          next_state = ppc_pkg::ST_XR_WAIT;
        end
      end
      ppc_pkg::ST_EPP_STB: begin
        // Strobe held until the peripheral raises wait, or timeout.
        if (busy_s2) begin
          next_state = ppc_pkg::ST_EPP_REL;
        end else if (tmo_hit) begin
          next_state = ppc_pkg::ST_IDLE;
        end
      end
      ppc_pkg::ST_EPP_REL: begin
        if (!busy_s2 || tmo_hit) begin
          next_state = ppc_pkg::ST_IDLE;
        end
      end
      ppc_pkg::ST_CMP_SETUP: begin
        // Data set up while the printer is still busy.
        if (!busy_s2) begin
          next_state = ppc_pkg::ST_CMP_STB;
        end
      end
      ppc_pkg::ST_CMP_STB: begin
        if (cnt == (ppc_pkg::CMP_STB_CYC - 12'h001)) begin
          next_state = ppc_pkg::ST_CMP_WAIT;
        end
      end
      ppc_pkg::ST_CMP_WAIT: begin
        // The acknowledge pulse closes the byte.
        if (ack_rise) begin
          next_state = ppc_pkg::ST_IDLE;
        end
      end
      ppc_pkg::ST_XF_CLK: begin
        if (busy_s2) begin
          next_state = ppc_pkg::ST_XF_REL;
        end
      end
      ppc_pkg::ST_XF_REL: begin
        if (!busy_s2) begin
          next_state = ppc_pkg::ST_IDLE;
        end
      end
      ppc_pkg::ST_XR_WAIT: begin
        // Leave if mode, direction or a full queue stops capture; else take the byte on clock low.
        if (!xr_go) begin
          next_state = ppc_pkg::ST_IDLE;
        end else if (!ack_s2) begin
          next_state = ppc_pkg::ST_XR_REL;
        end
      end
      ppc_pkg::ST_XR_REL: begin
        if (ack_s2) begin
          next_state = ppc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = ppc_pkg::ST_IDLE;
      end
    endcase
  end

  // Engine state, cycle counter and latched attributes.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ppc_pkg::ST_IDLE;
      cnt <= 12'h000;
      eng_addr <= 1'h0;
      eng_wr <= 1'h0;
      eng_byte <= 8'h00;
      epp_rx <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 12'h000 : cnt + 12'h001;
      if (epp_go) begin
        eng_addr <= hit_eaddr;
        eng_wr <= wr_i;
        eng_byte <= wdata_i;
      end else if (eng_pop) begin
        eng_byte <= fifo_head;
      end
      if (state == ppc_pkg::ST_EPP_STB && busy_s2 && !eng_wr) begin
        epp_rx <= pd_s2;
      end
    end
  end

  // Cable line values: control bits, except the lines the engine drives in its current cycle.
  logic next_stb_n, next_afd_n, next_select_in_line_ctrl_n, next_oe;
  always_comb begin
    next_stb_n = !ctrl_stb;
    next_afd_n = !ctrl_afd;
    next_select_in_line_ctrl_n = !ctrl_selin;
    next_oe = !ctrl_dir;
    case (state)
      ppc_pkg::ST_EPP_STB: begin
        next_stb_n = !eng_wr;
        next_select_in_line_ctrl_n = !eng_addr;
        next_afd_n = eng_addr;
        next_oe = eng_wr;
      end
      ppc_pkg::ST_EPP_REL: begin
        next_stb_n = !eng_wr;
        next_select_in_line_ctrl_n = 1'h1;
        next_afd_n = 1'h1;
        next_oe = eng_wr;
      end
      ppc_pkg::ST_CMP_SETUP, ppc_pkg::ST_CMP_WAIT: begin
        next_stb_n = 1'h1;
        next_oe = 1'h1;
      end
      ppc_pkg::ST_CMP_STB: begin
        next_stb_n = 1'h0;
        next_oe = 1'h1;
      end
      ppc_pkg::ST_XF_CLK, ppc_pkg::ST_XF_REL: begin
        next_stb_n = state != ppc_pkg::ST_XF_CLK;
        next_afd_n = 1'h1;
        next_oe = 1'h1;
      end
      ppc_pkg::ST_XR_WAIT, ppc_pkg::ST_XR_REL: begin
        next_afd_n = state == ppc_pkg::ST_XR_REL;
        next_oe = 1'h0;
      end
      default: begin
        next_oe = !ctrl_dir;
      end
    endcase
  end

  // Registered cable outputs.
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      strobe_n_o <= 1'h1;
      auto_feed_n_o <= 1'h1;
      select_in_n_o <= 1'h1;
      init_n_o <= 1'h0;
      pd_oe_o <= 1'h1;
      pd_o <= 8'h00;
    end else begin
      strobe_n_o <= next_stb_n;
      auto_feed_n_o <= next_afd_n;
      select_in_n_o <= next_select_in_line_ctrl_n;
      init_n_o <= ctrl_init;
      pd_oe_o <= next_oe;
      pd_o <= eng_byte;
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  AST_CTRL_RSVD: assert property (rd_i && hit_ctrl |=>
    rdata_o[7:6] == 2'h3)
    else $error("control reserved bits not 11");
  AST_DIR_COMPAT: assert property (m_compat |=> !ctrl_dir)
    else $error("direction not cleared in compatibility mode");
  AST_ACK_IRQ: assert property (ack_rise && ctrl_ackirq |=>
    irq_stat[ppc_pkg::IRQ_ACK] ##1 irq_o || !irq_mask[0])
    else $error("acknowledge edge did not raise interrupt");
  AST_STB_INV: assert property (idle |=>
    strobe_n_o == !$past(ctrl_stb) && select_in_n_o == !$past(ctrl_selin))
    else $error("idle strobe or select-in not inverted");
  AST_INIT: assert property (##1 init_n_o == $past(ctrl_init))
    else $error("initialize line differs from control bit");
  AST_ENHANCED_ADDRESS_BYTE: assert property (epp_go && hit_eaddr |=>
    state == ppc_pkg::ST_EPP_STB && eng_addr ##1 !select_in_n_o)
    else $error("address access did not start address cycle");
  AST_ENHANCED_DATA_BYTE: assert property (epp_go && hit_edata && wr_i |=>
    state == ppc_pkg::ST_EPP_STB && !eng_addr ##1 !auto_feed_n_o)
    else $error("data write did not start data cycle");
  AST_DFIFO_PUSH: assert property (wr_i && hit_fifo && m_dfifo &&
    !fifo_full |=> wr_ptr == $past(wr_ptr) + 5'h01)
    else $error("queue write in data queue mode lost");
  AST_TEST_QUIET: assert property (m_test && idle |=> idle)
    else $error("handshake started in test mode");
  AST_CFGA: assert property (rd_i && hit_fifo && m_cfg |=>
    rdata_o[6:4] == 3'h1 && rdata_o[1:0] == 2'h0 && rdata_o[7])
    else $error("configuration A read wrong");
  AST_TMO: assert property (state == ppc_pkg::ST_EPP_STB &&
    !busy_s2 && tmo_hit |=> irq_stat[ppc_pkg::IRQ_TMO] && idle)
    else $error("enhanced timeout not flagged");

  COV_EPP: cover property (state == ppc_pkg::ST_EPP_STB ##[1:20]
    state == ppc_pkg::ST_EPP_REL);
  COV_CMP: cover property (state == ppc_pkg::ST_CMP_WAIT ##1 idle);
  COV_XR: cover property (eng_push);
  COV_TMO: cover property (irq_set[ppc_pkg::IRQ_TMO]);
endmodule

// *** verif/cable_peer.sv ***
// Behavioural peripheral that answers the cable side of the parallel port.
`timescale 1ns/1ps
module cable_peer (
  // Clock and scenario controls from the bench.
  input wire logic clk_i,
  input wire logic [1:0] proto_i,
  input wire logic mute_i,
  input wire logic [3:0] lag_i,
  // Cable lines seen from the peripheral.
  input wire logic [7:0] pd_i,
  input wire logic strobe_n_i,
  input wire logic auto_feed_n_i,
  input wire logic select_in_n_i,
  output logic [7:0] pd_o,
  output logic pd_oe_o,
  output logic ack_n_o,
  output logic busy_o
);
  // Bytes taken from the host with an address flag, and bytes handed back.
  logic [8:0] seen[$];
  logic [7:0] gave[$];
  logic [7:0] nxt = 8'h3C;
  int sent = 0;
  // Answers are delayed by a bench-chosen number of cycles.
  task automatic pause();
    repeat (lag_i + 1) @(posedge clk_i);
  endtask
  // One process owns every peer output: idle levels, then the transfers.
  initial begin
    pd_o = 8'h00;
    pd_oe_o = 1'b0;
    ack_n_o = 1'b1;
    busy_o = 1'b0;
    // One transfer per pass, in the protocol that the bench selects.
    forever begin
      @(posedge clk_i);
      if (!mute_i && proto_i == 2'h0 && !strobe_n_i) begin
        // Compatibility byte: take data, then pulse acknowledge.
        seen.push_back({1'b0, pd_i});
        while (!strobe_n_i) @(posedge clk_i);
        pause();
        ack_n_o <= 1'b0;
        pause();
        ack_n_o <= 1'b1;
      end else if (!mute_i && proto_i == 2'h1 &&
                   !(select_in_n_i && auto_feed_n_i)) begin
        // Enhanced cycle: write takes data, read drives the next byte.
        if (!strobe_n_i) begin
          seen.push_back({!select_in_n_i, pd_i});
        end else begin
          pd_o <= nxt;
          pd_oe_o <= 1'b1;
          gave.push_back(nxt);
          nxt <= nxt + 8'h11;
        end
        pause();
        busy_o <= 1'b1;
        while (!(select_in_n_i && auto_feed_n_i)) @(posedge clk_i);
        pause();
        busy_o <= 1'b0;
        pd_oe_o <= 1'b0;
      end else if (!mute_i && proto_i == 2'h2 && !strobe_n_i) begin
        // Extended forward byte: host clock low, answer with busy.
        seen.push_back({1'b0, pd_i});
        pause();
        busy_o <= 1'b1;
        while (!strobe_n_i) @(posedge clk_i);
        pause();
        busy_o <= 1'b0;
      end else if (!mute_i && proto_i == 2'h3 && !auto_feed_n_i &&
                   sent < 4) begin
        // Extended reverse byte: drive data, then clock it with ack.
        pd_o <= nxt;
        pd_oe_o <= 1'b1;
        gave.push_back(nxt);
        nxt <= nxt + 8'h11;
        pause();
        ack_n_o <= 1'b0;
        while (!auto_feed_n_i) @(posedge clk_i);
        pause();
        ack_n_o <= 1'b1;
        pd_oe_o <= 1'b0;
        sent++;
      end
    end
  end
endmodule

// *** verif/parallel_port_ctrl_fifo_regs_bench.sv ***
// Self-checking bench for the parallel port register and cable block.
`timescale 1ns/1ps
module parallel_port_ctrl_fifo_regs_bench;
  // Design stimulus, design outputs and peer controls.
  logic clk_i, rstn_i, wr_i, rd_i, irq_o, pd_oe_o, oe_p, mute;
  logic strobe_n_o, auto_feed_n_o, init_n_o, select_in_n_o, ack_n, busy;
  logic [10:0] addr_i;
  logic [7:0] wdata_i, rdata_o, pd_o, pd_p, pd_w, v, w, x;
  // Undriven line pattern, and a peer entry with its address flag.
  logic [7:0] noise = 8'h5A;
  logic [8:0] y;
  logic [1:0] proto;
  logic [3:0] lag;
  logic [31:0] seed;
  logic [7:0] fq[$];
  int miscompares, total_checks;
  // Released data lines show a pattern that changes every cycle.
  assign pd_w = pd_oe_o ? pd_o : (oe_p ? pd_p : noise);
  parallel_port_ctrl_fifo_regs parallel_port_ctrl_fifo_regs_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .pd_i(pd_w), .pd_o(pd_o), .pd_oe_o(pd_oe_o), .strobe_n_o(strobe_n_o),
    .auto_feed_n_o(auto_feed_n_o), .init_n_o(init_n_o),
    .select_in_n_o(select_in_n_o), .ack_n_i(ack_n), .busy_i(busy));
  cable_peer cable_peer_i (
    .clk_i(clk_i), .proto_i(proto), .mute_i(mute), .lag_i(lag),
    .pd_i(pd_w), .strobe_n_i(strobe_n_o), .auto_feed_n_i(auto_feed_n_o),
    .select_in_n_i(select_in_n_o), .pd_o(pd_p), .pd_oe_o(oe_p),
    .ack_n_o(ack_n), .busy_o(busy));
  // Clock of 5 ns period.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Noise pattern for undriven data lines.
  always @(posedge clk_i) noise <= noise + 8'h3B;
  // Pseudo-random source.
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Byte comparison with mismatch report.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single line or flag comparison.
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // One-cycle register write followed by an idle cycle.
  task automatic reg_wr(input logic [10:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // One-cycle read; data is taken in the following cycle only.
  task automatic reg_rd(input logic [10:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask
  // Poll a register bit until it reaches a level, with a bound.
  task automatic poll(input logic [10:0] a, input int b, input logic lvl);
    int n;
    n = 0;
    do begin
      reg_rd(a, v);
      n++;
    end while (v[b] !== lvl && n < 3000);
    chk1(v[b], lvl);
  endtask
  // Wait for an empty queue and an idle engine.
  task automatic idle();
    poll(ppc_pkg::OFS_EXT_CTRL, 0, 1'b1);
    poll(ppc_pkg::OFS_ENG_STAT, 0, 1'b0);
  endtask
  task automatic mode_set(input ppc_pkg::port_operating_mode_t m);
    reg_wr(ppc_pkg::OFS_EXT_CTRL, {m, 5'h00});
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    test_done();
  end
  // Main sequence.
  initial begin
    rstn_i = 1'b0;
    addr_i = 11'h000;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    proto = 2'h0;
    mute = 1'b1;
    lag = 4'h0;
    seed = 32'h2FEE9478;
    miscompares = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk1(strobe_n_o, 1'b1);
    chk1(select_in_n_o, 1'b1);
    chk1(init_n_o, 1'b0);
    chk1(pd_oe_o, 1'b1);
    reg_rd(ppc_pkg::OFS_CTRL, v);
    chk8(v, 8'hC0);
    $display("test reset done");
    // Control register in both modes with random contents.
    for (int i = 0; i < 8; i++) begin
      mode_set(i[0] ? ppc_pkg::MODE_BIDIR : ppc_pkg::MODE_COMPAT);
      w = 8'(xs());
      reg_wr(ppc_pkg::OFS_CTRL, w);
      reg_rd(ppc_pkg::OFS_CTRL, v);
      chk8(v, {2'h3, i[0] & w[5], w[4:0]});
      chk1(strobe_n_o, ~w[0]);
      chk1(auto_feed_n_o, ~w[1]);
      chk1(init_n_o, w[2]);
      chk1(select_in_n_o, ~w[3]);
    end
    reg_wr(ppc_pkg::OFS_CTRL, 8'h00);
    $display("test control done");
    mode_set(ppc_pkg::MODE_CONFIG);
    reg_rd(ppc_pkg::OFS_FIFO, v);
    chk8(v, {ppc_pkg::CFGA_IRQ_LEVEL, 3'h1, 1'b0, ppc_pkg::CFGA_FULL_SEM,
             2'h0});
    reg_rd(ppc_pkg::OFS_EXT_CTRL, v);
    chk8({5'h00, v[7:5]}, 8'h07);
    // A queue write outside the queue modes must leave it empty.
    reg_wr(ppc_pkg::OFS_FIFO, 8'h5A);
    reg_rd(ppc_pkg::OFS_EXT_CTRL, v);
    chk1(v[0], 1'b1);
    $display("test config done");
    // Test mode: fill past full, drain past empty.
    mode_set(ppc_pkg::MODE_TEST);
    for (int i = 0; i < 17; i++) begin
      w = 8'(xs());
      reg_wr(ppc_pkg::OFS_FIFO, w);
      if (fq.size() < ppc_pkg::FIFO_DEPTH) fq.push_back(w);
    end
    reg_rd(ppc_pkg::OFS_EXT_CTRL, v);
    chk1(v[1], 1'b1);
    for (int i = 0; i < 17; i++) begin
      reg_rd(ppc_pkg::OFS_FIFO, v);
      x = (fq.size() > 0) ? fq.pop_front() : 8'h00;
      chk8(v, x);
    end
    reg_rd(ppc_pkg::OFS_EXT_CTRL, v);
    chk1(v[0], 1'b1);
    chk1(strobe_n_o, 1'b1);
    $display("test fifo done");
    // Enhanced address and data cycles.
    mode_set(ppc_pkg::MODE_ENH);
    proto <= 2'h1;
    mute <= 1'b0;
    for (int a = 3; a < 8; a++) begin
      w = 8'(xs());
      lag <= w[7:4];
      reg_wr(11'(a), w);
      poll(ppc_pkg::OFS_ENG_STAT, 0, 1'b0);
      y = cable_peer_i.seen.pop_front();
      chk8(y[7:0], w);
      chk1(y[8], a == 3);
      chk1(cable_peer_i.seen.size() == 0, 1'b1);
    end
    reg_rd(ppc_pkg::OFS_EADDR, v);
    chk8(v, 8'h00);
    poll(ppc_pkg::OFS_ENG_STAT, 0, 1'b0);
    reg_rd(ppc_pkg::OFS_EDATA_LO, v);
    chk8(v, cable_peer_i.gave.pop_front());
    poll(ppc_pkg::OFS_ENG_STAT, 0, 1'b0);
    reg_rd(ppc_pkg::OFS_EADDR, v);
    chk8(v, cable_peer_i.gave.pop_front());
    poll(ppc_pkg::OFS_ENG_STAT, 0, 1'b0);
    cable_peer_i.gave.delete();
    $display("test enhanced done");
    // Silent peripheral: timeout flag after 2000 cycles.
    mute <= 1'b1;
    reg_wr(ppc_pkg::OFS_IRQ_MASK, 8'h02);
    reg_wr(ppc_pkg::OFS_EDATA_HI, 8'hA5);
    repeat (1980) @(posedge clk_i);
    reg_rd(ppc_pkg::OFS_IRQ_STAT, v);
    chk1(v[1], 1'b0);
    poll(ppc_pkg::OFS_IRQ_STAT, 1, 1'b1);
    chk1(irq_o, 1'b1);
    reg_wr(ppc_pkg::OFS_IRQ_STAT, 8'h02);
    reg_rd(ppc_pkg::OFS_IRQ_STAT, v);
    chk1(v[1], 1'b0);
    chk1(irq_o, 1'b0);
    mute <= 1'b0;
    $display("test timeout done");
    // Compatibility queue with acknowledge interrupt on and off.
    mode_set(ppc_pkg::MODE_DFIFO);
    proto <= 2'h0;
    reg_wr(ppc_pkg::OFS_IRQ_MASK, 8'h01);
    for (int k = 0; k < 2; k++) begin
      reg_wr(ppc_pkg::OFS_CTRL, k == 0 ? 8'h10 : 8'h00);
      for (int i = 0; i < 3; i++) begin
        fq.push_back(8'(xs()));
        reg_wr(ppc_pkg::OFS_FIFO, fq[$]);
      end
      idle();
      repeat (3) begin
        y = cable_peer_i.seen.pop_front();
        chk8(y[7:0], fq.pop_front());
      end
      reg_rd(ppc_pkg::OFS_IRQ_STAT, v);
      chk1(v[0], k == 0);
      chk1(irq_o, k == 0);
      reg_wr(ppc_pkg::OFS_IRQ_STAT, 8'h01);
    end
    chk1(irq_o, 1'b0);
    $display("test compat done");
    // Extended forward, then reverse with the peer slow.
    mode_set(ppc_pkg::MODE_EXTCAP);
    proto <= 2'h2;
    for (int i = 0; i < 3; i++) begin
      fq.push_back(8'(xs()));
      reg_wr(ppc_pkg::OFS_FIFO, fq[$]);
    end
    idle();
    repeat (3) begin
      y = cable_peer_i.seen.pop_front();
      chk8(y[7:0], fq.pop_front());
    end
    chk1(auto_feed_n_o, 1'b1);
    proto <= 2'h3;
    lag <= 4'hF;
    reg_wr(ppc_pkg::OFS_CTRL, 8'h20);
    for (int i = 0; i < 4; i++) begin
      poll(ppc_pkg::OFS_EXT_CTRL, 0, 1'b0);
      reg_rd(ppc_pkg::OFS_FIFO, v);
      chk8(v, cable_peer_i.gave.pop_front());
    end
    chk1(pd_oe_o, 1'b0);
    $display("test extended done");
    test_done();
  end
endmodule
